// ### logic/rsc_cfg.svh
// Offsets, field positions, reset values and timing counts of the regulator control bank.
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RSC_ADDR_R1_ON 16'h4069
`define RSC_ADDR_R1_SLEEP 16'h406A
`define RSC_ADDR_R2_CTRL 16'h406B
`define RSC_ADDR_R2_ON 16'h406C
`define RSC_ADDR_R2_SLEEP 16'h406D
`define RSC_ADDR_IRQ_STATUS 16'h40F0
`define RSC_ADDR_IRQ_MASK 16'h40F1
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSC_SLOT_MSB 15
`define RSC_SLOT_LSB 13
`define RSC_MODE_BIT 8
`define RSC_VOLT_MSB 4
`define RSC_VOLT_LSB 0
`define RSC_FAULT_MSB 15
`define RSC_FAULT_LSB 14
`define RSC_HWSRC_MSB 12
`define RSC_HWSRC_LSB 11
`define RSC_HWVSEL_BIT 10
`define RSC_HWMODE_MSB 9
`define RSC_HWMODE_LSB 8
`define RSC_FLOAT_BIT 7
`define RSC_SWITCH_BIT 6
`define RSC_LPLEVEL_BIT 0
`define RSC_IRQ_UV_BIT 0
`define RSC_IRQ_SLEEP_BIT 1
`define RSC_IRQ_WAKE_BIT 2
// ----------------------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------------------
`define RSC_RST_ON 16'h0000
`define RSC_RST_SLEEP 16'h0100
`define RSC_RST_R2_CTRL 16'h0200
`define RSC_RST_IRQ_MASK 16'h0007
`define RSC_WMASK_SLOTREG 16'hE11F
`define RSC_WMASK_R2_CTRL 16'hDFC1
`define RSC_WMASK_IRQ 16'h0007
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RSC_CLK_PERIOD_NS 4
`define RSC_SLOT_TIME_NS 1000
`define RSC_SLOT_CYCLES ((`RSC_SLOT_TIME_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`endif

// ### logic/rsc_pkg.sv
// Types and helper functions shared by the regulator control bank.
package rsc_pkg;
  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    RSC_SEQ_IDLE = 3'h1,
    RSC_SEQ_WAKE = 3'h2,
    RSC_SEQ_SLEEP = 3'h4
  } rsc_seq_state_type;
  // --------------------------------------------------------------------------
  // Field encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_FAULT_IGNORE = 2'h0,
    RSC_FAULT_REG_OFF = 2'h1,
    RSC_FAULT_SYS_RESET = 2'h2,
    RSC_FAULT_RESERVED = 2'h3
  } rsc_fault_type;
  typedef enum logic [1:0] {
    RSC_HWSRC_NONE = 2'h0,
    RSC_HWSRC_IN1 = 2'h1,
    RSC_HWSRC_IN2 = 2'h2,
    RSC_HWSRC_EITHER = 2'h3
  } rsc_hwsrc_type;
  // Timeslot in which a sleep slot code takes effect.
  function automatic logic [2:0] rsc_sleep_target(input logic [2:0] code);
    logic [2:0] slot;
    slot = 3'h5;
    case (code)
      3'h0: slot = 3'h5;
      3'h1: slot = 3'h5;
      3'h2: slot = 3'h4;
      3'h3: slot = 3'h3;
      3'h4: slot = 3'h2;
      3'h5: slot = 3'h1;
      3'h6: slot = 3'h3;
      3'h7: slot = 3'h1;
      default: slot = 3'h5;
    endcase
    return slot;
  endfunction
  // Codes that switch the regulator off rather than moving it to sleep settings.
  function automatic logic rsc_is_disable(input logic [2:0] code);
    return (code >= 3'h1) && (code <= 3'h5);
  endfunction
endpackage

// ### logic/rsc_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module rsc_sync
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins
  input wire logic [2:0] i_pin,
  // Filtered levels
  output logic [2:0] o_level
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
    end
    else
    begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change is taken only once the last two stages agree, so a metastable
  // settle in the first stage never reaches the filtered level.
  for (genvar b = 0; b < 3; b++)
  begin : g_bit
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        o_level[b] <= 1'b0;
      else if (s2[b] == s3[b])
        o_level[b] <= s3[b];
    end
  end
endmodule

// ### logic/rsc_seq.sv
// Timeslot sequencer stepping five slots upward for wake and downward for sleep.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_seq
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Requests
  input wire logic i_sleep_req,
  input wire logic i_wake_req,
  // Slot progress
  output logic o_tick,
  output logic [2:0] o_slot,
  output logic o_sleeping,
  output logic o_busy,
  output logic o_wake_done,
  output logic o_sleep_done
);
  localparam logic [11:0] SLOT_LAST = 12'(`RSC_SLOT_CYCLES - 1);
  rsc_seq_state_type state;
  logic [11:0] cnt;

  assign o_sleeping = (state == RSC_SEQ_SLEEP);
  assign o_busy = (state != RSC_SEQ_IDLE);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= RSC_SEQ_IDLE;
      o_slot <= 3'h0;
      cnt <= 12'h000;
      o_tick <= 1'b0;
      o_wake_done <= 1'b0;
      o_sleep_done <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      o_wake_done <= 1'b0;
      o_sleep_done <= 1'b0;
      case (state)
        RSC_SEQ_IDLE:
        begin
          if (i_wake_req)
          begin
            state <= RSC_SEQ_WAKE;
            o_slot <= 3'h1;
            o_tick <= 1'b1;
            cnt <= SLOT_LAST;
          end
          else if (i_sleep_req)
          begin
            state <= RSC_SEQ_SLEEP;
            o_slot <= 3'h5;
            o_tick <= 1'b1;
            cnt <= SLOT_LAST;
          end
        end
        RSC_SEQ_WAKE:
        begin
          if (cnt != 12'h000)
            cnt <= cnt - 12'h001;
          else if (o_slot == 3'h5)
          begin
            state <= RSC_SEQ_IDLE;
            o_slot <= 3'h0;
            o_wake_done <= 1'b1;
          end
          else
          begin
            o_slot <= o_slot + 3'h1;
            o_tick <= 1'b1;
            cnt <= SLOT_LAST;
          end
        end
        RSC_SEQ_SLEEP:
        begin
          if (cnt != 12'h000)
            cnt <= cnt - 12'h001;
          else if (o_slot == 3'h1)
          begin
            state <= RSC_SEQ_IDLE;
            o_slot <= 3'h0;
            o_sleep_done <= 1'b1;
          end
          else
          begin
            o_slot <= o_slot - 3'h1;
            o_tick <= 1'b1;
            cnt <= SLOT_LAST;
          end
        end
        default:
          state <= RSC_SEQ_IDLE;
      endcase
    end
  end
endmodule

// ### logic/rsc_regs.sv
// Sleep and control registers of two linear regulators with their sequencing logic.
`timescale 1ns/1ps
`include "rsc_cfg.svh"
// Functional notes
// - Sleep slot code 000 moves the first regulator to sleep settings in slot 5, enabled.
// - Sleep slot codes 001 to 101 disable it in slots 5, 4, 3, 2 and 1.
// - Code 110 applies sleep settings in slot 3 and 111 in slot 1, leaving it enabled.
// - With a hardware enable, codes 001 to 101 pick the slot of sleep entry instead.
// - Sleep mode bit 8 picks normal (0) or low power (1) while asleep, reset 1.
// - The five-bit sleep voltage code in bits 4:0 drives the output code while asleep.
// - Fault action bits 15:14 ignore, switch off the regulator, or reset the system.
// - An undervoltage always sets status bit 0, whatever the fault action, and raises the interrupt when mask bit 0 is clear.
// - Hardware source bits 12:11 pick none, input 1, input 2 or either input.
// - Under hardware control bit 10 picks the ON (0) or sleep (1) voltage code.
// - Hardware mode bits 9:8 give low power for 00 or 10, off for 01, ON mode for 11.
// - Float bit 7 discharges a disabled output when 0 and leaves it floating when 1.
// - Low power level bit 0 picks the 50mA (0) or 20mA (1) level in all modes.
// - ON slot 000 never enables, 001 to 101 enable in slots 1 to 5, 110/111 follow pins.
module rsc_regs
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Sequencer requests
  input wire logic i_sleep_req,
  input wire logic i_wake_req,
  output logic o_seq_busy,
  // Pins
  input wire logic i_hw_ctrl1,
  input wire logic i_hw_ctrl2,
  input wire logic i_reg2_undervoltage,
  // First regulator
  output logic o_reg1_enable,
  output logic o_reg1_in_sleep,
  output logic [4:0] o_reg1_voltage,
  output logic o_reg1_low_power,
  // Second regulator
  output logic o_reg2_enable,
  output logic [4:0] o_reg2_voltage,
  output logic o_reg2_low_power,
  output logic o_reg2_discharge,
  output logic o_reg2_switch_mode,
  output logic o_reg2_low_power_level,
  // System
  output logic o_system_reset,
  output logic o_irq
);
  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  localparam int NREG = 6;
  localparam logic [15:0] REG_ADDR [NREG] = '{`RSC_ADDR_R1_ON, `RSC_ADDR_R1_SLEEP,
    `RSC_ADDR_R2_CTRL, `RSC_ADDR_R2_ON, `RSC_ADDR_R2_SLEEP, `RSC_ADDR_IRQ_MASK};
  localparam logic [15:0] REG_RST [NREG] = '{`RSC_RST_ON, `RSC_RST_SLEEP,
    `RSC_RST_R2_CTRL, `RSC_RST_ON, `RSC_RST_SLEEP, `RSC_RST_IRQ_MASK};
  localparam logic [15:0] REG_WMASK [NREG] = '{`RSC_WMASK_SLOTREG, `RSC_WMASK_SLOTREG,
    `RSC_WMASK_R2_CTRL, `RSC_WMASK_SLOTREG, `RSC_WMASK_SLOTREG, `RSC_WMASK_IRQ};
  logic [15:0] regs [NREG];
  logic [15:0] irq_status;

  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        regs[i] <= REG_RST[i];
      else if (i_wr && (i_addr == REG_ADDR[i]))
        regs[i] <= i_wdata & REG_WMASK[i];
    end
  end

  // --------------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------------
  logic [2:0] r1_on_slot;
  logic [4:0] r1_on_volt;
  logic r1_on_mode;
  logic [2:0] r1_slp_slot;
  logic r1_slp_mode;
  logic [4:0] r1_slp_volt;
  logic [1:0] r2_fault_action;
  logic [1:0] r2_hw_ctrl_source;
  logic r2_hw_ctrl_voltage_choice;
  logic [1:0] r2_hw_ctrl_opmode;
  logic r2_output_float;
  logic [2:0] r2_on_slot;
  logic [4:0] r2_on_volt;
  logic r2_on_mode;
  logic [4:0] r2_slp_volt;
  logic [15:0] irq_mask;

  assign r1_on_slot = regs[0][`RSC_SLOT_MSB:`RSC_SLOT_LSB];
  assign r1_on_mode = regs[0][`RSC_MODE_BIT];
  assign r1_on_volt = regs[0][`RSC_VOLT_MSB:`RSC_VOLT_LSB];
  assign r1_slp_slot = regs[1][`RSC_SLOT_MSB:`RSC_SLOT_LSB];
  assign r1_slp_mode = regs[1][`RSC_MODE_BIT];
  assign r1_slp_volt = regs[1][`RSC_VOLT_MSB:`RSC_VOLT_LSB];
  assign r2_fault_action = regs[2][`RSC_FAULT_MSB:`RSC_FAULT_LSB];
  assign r2_hw_ctrl_source = regs[2][`RSC_HWSRC_MSB:`RSC_HWSRC_LSB];
  assign r2_hw_ctrl_voltage_choice = regs[2][`RSC_HWVSEL_BIT];
  assign r2_hw_ctrl_opmode = regs[2][`RSC_HWMODE_MSB:`RSC_HWMODE_LSB];
  assign r2_output_float = regs[2][`RSC_FLOAT_BIT];
  assign r2_on_slot = regs[3][`RSC_SLOT_MSB:`RSC_SLOT_LSB];
  assign r2_on_mode = regs[3][`RSC_MODE_BIT];
  assign r2_on_volt = regs[3][`RSC_VOLT_MSB:`RSC_VOLT_LSB];
  assign r2_slp_volt = regs[4][`RSC_VOLT_MSB:`RSC_VOLT_LSB];
  assign irq_mask = regs[5];

  // --------------------------------------------------------------------------
  // Pins and sequencer
  // --------------------------------------------------------------------------
  logic [2:0] pin_level;
  logic hw1;
  logic hw2;
  logic uv;
  logic uv_q;
  logic uv_edge;
  logic seq_tick;
  logic [2:0] seq_slot;
  logic seq_sleeping;
  logic seq_busy;
  logic wake_done;
  logic sleep_done;

  rsc_sync u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin({i_reg2_undervoltage, i_hw_ctrl2, i_hw_ctrl1}),
    .o_level(pin_level)
  );

  rsc_seq u_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sleep_req(i_sleep_req),
    .i_wake_req(i_wake_req),
    .o_tick(seq_tick),
    .o_slot(seq_slot),
    .o_sleeping(seq_sleeping),
    .o_busy(seq_busy),
    .o_wake_done(wake_done),
    .o_sleep_done(sleep_done)
  );

  assign hw1 = pin_level[0];
  assign hw2 = pin_level[1];
  assign uv = pin_level[2];
  assign uv_edge = uv & ~uv_q;

  // --------------------------------------------------------------------------
  // First regulator sequencing
  // --------------------------------------------------------------------------
  logic r1_en;
  logic r1_slp;
  logic r1_hw_assigned;
  logic r1_hw_level;
  logic [2:0] r1_target;

  assign r1_hw_assigned = (r1_on_slot == 3'h6) || (r1_on_slot == 3'h7);
  assign r1_hw_level = (r1_on_slot == 3'h6) ? hw1 : hw2;
  assign r1_target = rsc_sleep_target(r1_slp_slot);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r1_en <= 1'b0;
      r1_slp <= 1'b0;
    end
    else if (seq_tick && !seq_sleeping)
    begin
      if ((seq_slot == r1_on_slot) && !r1_hw_assigned)
        r1_en <= 1'b1;
      if (seq_slot == 3'h1)
        r1_slp <= 1'b0;
    end
    else if (seq_tick && (seq_slot == r1_target))
    begin
      if (rsc_is_disable(r1_slp_slot) && !r1_hw_assigned)
        r1_en <= 1'b0;
      // Transition in the target slot of code 000, 110 or 111, or of any code under a hardware enable.
      else
        r1_slp <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Second regulator control
  // --------------------------------------------------------------------------
  logic r2_en;
  logic r2_fault_off;
  logic r2_hw_active;
  logic r2_hw_assigned;
  logic next_reg2_enable;
  logic next_reg2_low_power;

  always_comb
  begin
    case (rsc_hwsrc_type'(r2_hw_ctrl_source))
      RSC_HWSRC_NONE: r2_hw_active = 1'b0;
      RSC_HWSRC_IN1: r2_hw_active = hw1;
      RSC_HWSRC_IN2: r2_hw_active = hw2;
      RSC_HWSRC_EITHER: r2_hw_active = hw1 | hw2;
      default: r2_hw_active = 1'b0;
    endcase
  end

  assign r2_hw_assigned = (r2_on_slot == 3'h6) || (r2_on_slot == 3'h7);

  always_comb
  begin
    next_reg2_enable = r2_hw_assigned ? ((r2_on_slot == 3'h6) ? hw1 : hw2) : r2_en;
    next_reg2_low_power = r2_on_mode;
    if (r2_fault_off)
      next_reg2_enable = 1'b0;
    else if (r2_hw_active)
    begin
      case (r2_hw_ctrl_opmode)
        2'h1: next_reg2_enable = 1'b0;
        2'h3: next_reg2_low_power = r2_on_mode;
        default: next_reg2_low_power = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      r2_en <= 1'b0;
    else if (seq_tick && !seq_sleeping && (seq_slot == r2_on_slot) && !r2_hw_assigned)
      r2_en <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      uv_q <= 1'b0;
      r2_fault_off <= 1'b0;
      o_system_reset <= 1'b0;
    end
    else
    begin
      uv_q <= uv;
      o_system_reset <= uv_edge && (r2_fault_action == RSC_FAULT_SYS_RESET);
      if (uv_edge && (r2_fault_action == RSC_FAULT_REG_OFF))
        r2_fault_off <= 1'b1;
      else if (seq_tick && !seq_sleeping && (seq_slot == 3'h1))
        r2_fault_off <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_reg1_enable <= 1'b0;
      o_reg1_in_sleep <= 1'b0;
      o_reg1_voltage <= 5'h00;
      o_reg1_low_power <= 1'b0;
      o_reg2_enable <= 1'b0;
      o_reg2_voltage <= 5'h00;
      o_reg2_low_power <= 1'b0;
      o_reg2_discharge <= 1'b1;
      o_reg2_switch_mode <= 1'b0;
      o_reg2_low_power_level <= 1'b0;
      o_seq_busy <= 1'b0;
    end
    else
    begin
      o_reg1_enable <= r1_hw_assigned ? r1_hw_level : r1_en;
      o_reg1_in_sleep <= r1_slp;
      o_reg1_low_power <= r1_slp ? r1_slp_mode : r1_on_mode;
      o_reg1_voltage <= r1_slp ? r1_slp_volt : r1_on_volt;
      o_reg2_enable <= next_reg2_enable;
      o_reg2_voltage <= (r2_hw_active && r2_hw_ctrl_voltage_choice) ? r2_slp_volt : r2_on_volt;
      o_reg2_low_power <= next_reg2_low_power;
      o_reg2_discharge <= !next_reg2_enable && !r2_output_float;
      o_reg2_switch_mode <= regs[2][`RSC_SWITCH_BIT];
      o_reg2_low_power_level <= regs[2][`RSC_LPLEVEL_BIT];
      o_seq_busy <= seq_busy;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts and read path
  // --------------------------------------------------------------------------
  logic [15:0] irq_set;
  logic [15:0] irq_clr;

  assign irq_set = {13'h0000, wake_done, sleep_done, uv_edge};
  assign irq_clr = (i_wr && (i_addr == `RSC_ADDR_IRQ_STATUS)) ? i_wdata : 16'h0000;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      irq_status <= 16'h0000;
    else
      irq_status <= ((irq_status & ~irq_clr) | irq_set) & `RSC_WMASK_IRQ;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_status & ~irq_mask);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else if (!i_rd)
      o_rdata <= 16'h0000;
    else
    begin
      case (i_addr)
        `RSC_ADDR_R1_ON: o_rdata <= regs[0];
        `RSC_ADDR_R1_SLEEP: o_rdata <= regs[1];
        `RSC_ADDR_R2_CTRL: o_rdata <= regs[2];
        `RSC_ADDR_R2_ON: o_rdata <= regs[3];
        `RSC_ADDR_R2_SLEEP: o_rdata <= regs[4];
        `RSC_ADDR_IRQ_MASK: o_rdata <= regs[5];
        `RSC_ADDR_IRQ_STATUS: o_rdata <= irq_status;
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_slot5_transition: assert property (
    (seq_tick && seq_sleeping && seq_slot == 3'h5 && r1_slp_slot == 3'h0 && r1_en)
    |=> ##1 (o_reg1_in_sleep && o_reg1_enable == !r1_hw_assigned || r1_hw_assigned))
    else $error("code 000 did not reach sleep settings enabled in slot 5");
  chk_disable_slot: assert property (
    (seq_tick && seq_sleeping && seq_slot == r1_target && rsc_is_disable(r1_slp_slot)
     && !r1_hw_assigned) |=> ##1 !o_reg1_enable)
    else $error("regulator not disabled in its sleep slot");
  chk_keep_enabled: assert property (
    (seq_tick && seq_sleeping && seq_slot == r1_target && r1_slp_slot[2:1] == 2'h3 && r1_en)
    |=> (r1_en && r1_slp))
    else $error("transition code disabled the regulator");
  chk_hw_sleep_entry: assert property (
    (seq_tick && seq_sleeping && seq_slot == r1_target && r1_hw_assigned) |=> r1_slp)
    else $error("hardware enabled regulator did not enter sleep");
  chk_sleep_voltage: assert property (
    (r1_slp && $stable(r1_slp_volt)) |=> (o_reg1_voltage == $past(r1_slp_volt)))
    else $error("sleep voltage code not applied");
  chk_uv_irq: assert property (
    (uv_edge && !irq_mask[`RSC_IRQ_UV_BIT]) |=> irq_status[`RSC_IRQ_UV_BIT] ##1 o_irq)
    else $error("undervoltage did not raise the interrupt");
  chk_sys_reset: assert property (
    o_system_reset |-> $past(uv_edge) && $past(r2_fault_action) == 2'h2)
    else $error("system reset without its fault action");
  chk_hw_off: assert property (
    (r2_hw_active && r2_hw_ctrl_opmode == 2'h1) |=> !o_reg2_enable)
    else $error("hardware off mode left the regulator enabled");
  chk_discharge: assert property (
    (o_reg2_enable && o_reg2_discharge) == 1'b0)
    else $error("output discharged while enabled");
  chk_slot_order: assert property (
    (seq_tick && seq_sleeping && $past(seq_busy)) |-> (seq_slot == $past(seq_slot) - 3'h1))
    else $error("sleep slots out of descending order");

  cov_sleep_done: cover property (sleep_done);
  cov_wake_done: cover property (wake_done);
  cov_uv_irq: cover property (uv_edge ##2 o_irq);
  cov_hw_ctrl: cover property (r2_hw_active && r2_hw_ctrl_voltage_choice);
endmodule

// ### verif/rsc_pin_model.sv
// Model of the hardware control and undervoltage pins outside the bank.
`timescale 1ns/1ps
module rsc_pin_model
(
  // Clock
  input wire logic i_clk,
  // Pins
  output logic o_hw_ctrl1,
  output logic o_hw_ctrl2,
  output logic o_undervoltage
);
  initial {o_undervoltage, o_hw_ctrl2, o_hw_ctrl1} = 3'h0;
  // Pins move just after an edge and then hold, so the synchroniser sees clean levels.
  task automatic set_pins(input logic [2:0] v);
    @(posedge i_clk);
    {o_undervoltage, o_hw_ctrl2, o_hw_ctrl1} <= v;
  endtask
endmodule

// ### verif/rsc_regs_tb.sv
// Self-checking bench of the regulator control bank.
`timescale 1ns/1ps
module rsc_regs_tb;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_sleep_req = 1'b0, i_wake_req = 1'b0;
  logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, o_rdata;
  logic i_hw_ctrl1, i_hw_ctrl2, i_reg2_undervoltage, o_seq_busy, o_reg1_enable, o_reg1_in_sleep;
  logic o_reg1_low_power, o_reg2_enable, o_reg2_low_power, o_reg2_discharge, o_reg2_switch_mode;
  logic o_reg2_low_power_level, o_system_reset, o_irq;
  logic [4:0] o_reg1_voltage, o_reg2_voltage;
  int failures = 0, total_checks = 0;
  rsc_regs rsc_regs_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sleep_req,
    .i_wake_req, .o_seq_busy, .i_hw_ctrl1, .i_hw_ctrl2, .i_reg2_undervoltage, .o_reg1_enable,
    .o_reg1_in_sleep, .o_reg1_voltage, .o_reg1_low_power, .o_reg2_enable, .o_reg2_voltage,
    .o_reg2_low_power, .o_reg2_discharge, .o_reg2_switch_mode, .o_reg2_low_power_level,
    .o_system_reset, .o_irq);
  rsc_pin_model rsc_pin_model_i (.i_clk(i_clk), .o_hw_ctrl1(i_hw_ctrl1),
    .o_hw_ctrl2(i_hw_ctrl2), .o_undervoltage(i_reg2_undervoltage));
  initial
  begin
    forever #2 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic req(input logic sleep);
    @(posedge i_clk);
    i_sleep_req <= sleep;
    i_wake_req <= !sleep;
    @(posedge i_clk);
    {i_sleep_req, i_wake_req} <= 2'h0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge i_clk);
    while (o_seq_busy === 1'b1 && n < 1500)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 1500)
    begin
      failures++;
      report_and_stop;
    end
    #1;
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_fields;
    rd(16'h406A, 16'h0100);
    rd(16'h406B, 16'h0200);
    rd(16'h4000, 16'h0000);
    wr(16'h406B, 16'hFFFF);
    rd(16'h406B, 16'hDFC1);
    repeat (3) @(posedge i_clk);
    chk(16'({o_reg2_switch_mode, o_reg2_low_power_level}), 16'h0003);
    chk(16'(o_reg2_discharge), 16'h0000);
    wr(16'h406B, 16'h0200);
    repeat (3) @(posedge i_clk);
    chk(16'(o_reg2_discharge), 16'h0001);
    wr(16'h406D, 16'h0015);
    wr(16'h406B, 16'h0F00);
    rsc_pin_model_i.set_pins(3'h1);
    repeat (10) @(posedge i_clk);
    chk(16'(o_reg2_voltage), 16'h0015);
    chk(16'(o_reg2_low_power), 16'h0000);
    wr(16'h406C, 16'hC000);
    wr(16'h406B, 16'h1400);
    repeat (3) @(posedge i_clk);
    chk(16'({o_reg2_enable, o_reg2_low_power, o_reg2_voltage}), 16'h0040);
    rsc_pin_model_i.set_pins(3'h3);
    repeat (10) @(posedge i_clk);
    chk(16'({o_reg2_enable, o_reg2_low_power, o_reg2_voltage}), 16'h0075);
    wr(16'h406B, 16'h1500);
    repeat (3) @(posedge i_clk);
    chk(16'({o_reg2_enable, o_reg2_discharge}), 16'h0001);
    rsc_pin_model_i.set_pins(3'h0);
    wr(16'h406C, 16'h0000);
    wr(16'h406B, 16'h0200);
    $display("field test done");
  endtask
  task automatic test_fault;
    int n;
    wr(16'h40F1, 16'h0006);
    rsc_pin_model_i.set_pins(3'h4);
    repeat (10) @(posedge i_clk);
    rsc_pin_model_i.set_pins(3'h0);
    rd(16'h40F0, 16'h0001);
    chk(16'(o_irq), 16'h0001);
    wr(16'h40F0, 16'h0001);
    repeat (3) @(posedge i_clk);
    chk(16'(o_irq), 16'h0000);
    wr(16'h406B, 16'h8200);
    rsc_pin_model_i.set_pins(3'h4);
    n = 0;
    while (o_system_reset !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    chk(16'(n < 20), 16'h0001);
    if (n >= 20)
      report_and_stop;
    rsc_pin_model_i.set_pins(3'h0);
    wr(16'h406C, 16'hC000);
    wr(16'h406B, 16'h4200);
    rsc_pin_model_i.set_pins(3'h1);
    repeat (10) @(posedge i_clk);
    chk(16'(o_reg2_enable), 16'h0001);
    rsc_pin_model_i.set_pins(3'h5);
    repeat (10) @(posedge i_clk);
    chk(16'(o_reg2_enable), 16'h0000);
    rsc_pin_model_i.set_pins(3'h0);
    wr(16'h406C, 16'h0000);
    wr(16'h406B, 16'h0200);
    wr(16'h40F0, 16'h0007);
    $display("fault test done");
  endtask
  task automatic test_sleep;
    int n;
    wr(16'h4069, 16'h2000);
    req(1'b0);
    wait_idle;
    chk(16'(o_reg1_enable), 16'h0001);
    wr(16'h406A, 16'h001F);
    req(1'b1);
    wait_idle;
    chk(16'({o_reg1_enable, o_reg1_in_sleep}), 16'h0003);
    chk(16'({o_reg1_low_power, o_reg1_voltage}), 16'h001F);
    for (int c = 1; c <= 5; c++)
    begin
      req(1'b0);
      wait_idle;
      wr(16'h406A, 16'(c << 13));
      req(1'b1);
      n = 0;
      while (o_reg1_enable === 1'b1 && n < 1400)
      begin
        @(posedge i_clk);
        n++;
      end
      n = n - (c - 1) * 250;
      chk(16'(n >= 1 && n <= 8), 16'h0001);
      if (o_reg1_enable === 1'b1)
        report_and_stop;
      wait_idle;
    end
    $display("sleep test done");
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    test_fields;
    test_fault;
    test_sleep;
    report_and_stop;
  end
endmodule
